// [rtl/fbc_cyc_if.sv]
/*
 interface carrying one flash bus cycle request from the sequencer to the pin engine.
 assumes a single clock shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none
interface fbc_cyc_if #(parameter int AW = 23);
	logic req;
	logic wr;
	logic [AW-1:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	modport seq (output req, output wr, output addr, output wdata, input ack, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

// [rtl/fbc_host.sv]
/*
 flash command sequencer: software posts one operation over apb, the sequencer
 writes the matching unlock and command cycles to a byte-mode nor flash.
 assumes the flash is wired to the pin engine outputs and apb is on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module fbc_host
	import fbc_pkg::*;
#(
	parameter int AW = 23,
	parameter int BUF_MAX_CYC = 261
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	// flash pins
	output logic [AW-1:0] fl_addr_q,
	output logic fl_ce_n_q,
	output logic fl_we_n_q,
	output logic fl_oe_n_q,
	output logic [7:0] fl_dq_out_q,
	output logic fl_dq_oe_q,
	input wire logic [7:0] fl_dq_in,
	output logic acceleration_input_q
);
	initial begin
		if (AW < 12 || BUF_MAX_CYC < 6 || BUF_MAX_CYC > 1023)
			$error("unsupported parameters");
	end
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_WAIT = 2'b10
	} fbc_state_type;
	fbc_state_type st_q;
	fbc_op_type op_q;
	logic [AW-1:0] addr_q;
	logic [7:0] data_q;
	logic [7:0] rdat_q;
	logic [31:0] pwd_q;
	logic [3:0] step_q;
	logic [9:0] buf_cyc_q;
	logic done_q;
	logic refuse_q;
	logic in_bypass_q;
	logic in_wbuf_q;
	logic [3:0] nsteps;
	logic step_wr;
	logic [AW-1:0] step_addr;
	logic [7:0] step_data;
	logic apb_wr;
	logic apb_rd;
	logic go;
	logic legal;
	fbc_op_type go_op;
	fbc_cyc_if #(.AW(AW)) cyc ();

	fbc_pin_engine #(.AW(AW)) u_eng (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.cyc(cyc),
		.fl_addr_q(fl_addr_q),
		.fl_ce_n_q(fl_ce_n_q),
		.fl_we_n_q(fl_we_n_q),
		.fl_oe_n_q(fl_oe_n_q),
		.fl_dq_out_q(fl_dq_out_q),
		.fl_dq_oe_q(fl_dq_oe_q),
		.fl_dq_in(fl_dq_in)
	);

	assign apb_wr = psel && penable && pwrite && !pready_q;
	assign apb_rd = psel && penable && !pwrite && !pready_q;
	assign go = apb_wr && paddr == REG_CTRL && pwdata[CTRL_GO_BIT];
	assign go_op = fbc_op_type'(pwdata[CTRL_OP_LSB +: CTRL_OP_W]);

	// refuse bypass-only ops outside bypass, buffer loads outside a buffer sequence
	always_comb begin
		legal = (st_q == ST_IDLE);
		unique case (go_op)
			OP_BYP_PROG, OP_BYP_SECT, OP_BYP_CHIP: legal = legal && in_bypass_q;
			OP_WBUF_LOAD: legal = legal && in_wbuf_q && buf_cyc_q < 10'(BUF_MAX_CYC - 1);
			OP_WBUF_CONFIRM: legal = legal && in_wbuf_q;
			default: legal = legal;
		endcase
	end

	// cycle table: (write, address, data) for each step of each op
	function automatic logic [AW+8:0] cyc_of(input logic [3:0] s, input logic [7:0] c);
		logic [AW-1:0] a;
		a = AW'(s == 4'd1 ? ADR_555 : ADR_AAA);
		cyc_of = {1'b1, a, s == 4'd1 ? CD_55 : (s == 4'd0 ? CD_AA : c)};
	endfunction

	always_comb begin
		nsteps = 4'd1;
		step_wr = 1'b1;
		step_addr = '0;
		step_data = data_q;
		unique case (op_q)
			OP_READ: begin
				step_wr = 1'b0;
				step_addr = addr_q;
			end
			OP_RESET, OP_SUSP_LEG, OP_RES_LEG, OP_SUSP_ENH, OP_RES_ENH: begin
				step_data = op_q == OP_RESET ? CD_RESET : op_q == OP_SUSP_LEG ? CD_SUSP_LEG :
					op_q == OP_RES_LEG ? CD_RES_LEG : op_q == OP_SUSP_ENH ? CD_SUSP_ENH :
					CD_RES_ENH;
			end
			OP_PROG: begin
				nsteps = 4'd4;
				{step_wr, step_addr, step_data} = cyc_of(step_q, CD_PROG);
				if (step_q == 4'd3) begin
					step_addr = addr_q;
					step_data = data_q;
				end
			end
			OP_CHIP_ERASE, OP_SECT_ERASE: begin
				nsteps = 4'd6;
				{step_wr, step_addr, step_data} = cyc_of(step_q < 4'd3 ? step_q : step_q - 4'd3,
					step_q == 4'd2 ? CD_ERASE : (op_q == OP_CHIP_ERASE ? CD_CHIP : CD_SECT));
				if (step_q == 4'd5 && op_q == OP_SECT_ERASE)
					step_addr = addr_q;
			end
			OP_BYP_ENTER, OP_ABORT_RST, OP_SR_CLEAR, OP_SR_READ: begin
				nsteps = op_q == OP_SR_READ ? 4'd2 : op_q == OP_SR_CLEAR ? 4'd1 : 4'd3;
				{step_wr, step_addr, step_data} = cyc_of(step_q,
					op_q == OP_BYP_ENTER ? CD_BYPASS : CD_RESET);
				if (op_q == OP_SR_READ || op_q == OP_SR_CLEAR) begin
					step_addr = step_q == 4'd0 ? AW'(ADR_AAA) : '0;
					step_data = op_q == OP_SR_READ ? CD_SRRD : CD_SRCLR;
					step_wr = step_q == 4'd0;
				end
			end
			OP_BYP_PROG, OP_PWD_PROG, OP_NVLB_SET, OP_VLB_SET, OP_VLB_CLR: begin
				nsteps = 4'd2;
				step_data = step_q == 4'd0 ? CD_PROG : (op_q == OP_NVLB_SET || op_q == OP_VLB_SET) ?
					CD_ZERO : op_q == OP_VLB_CLR ? CD_ONE : data_q;
				if (step_q == 4'd1)
					step_addr = op_q == OP_PWD_PROG ? AW'(addr_q[1:0]) : addr_q;
			end
			OP_BYP_SECT, OP_BYP_CHIP, OP_NVLB_ERASE, OP_EXIT: begin
				nsteps = 4'd2;
				step_data = step_q == 4'd0 ? (op_q == OP_EXIT ? CD_AUTOSEL : CD_ERASE) :
					op_q == OP_EXIT ? CD_ZERO : op_q == OP_BYP_CHIP ? CD_CHIP : CD_SECT;
				if (step_q == 4'd1 && op_q == OP_BYP_SECT)
					step_addr = addr_q;
			end
			OP_PROT_VERIFY, OP_SECURE_STAT: begin
				nsteps = 4'd4;
				{step_wr, step_addr, step_data} = cyc_of(step_q, CD_AUTOSEL);
				if (step_q == 4'd3) begin
					step_wr = 1'b0;
					step_addr = op_q == OP_SECURE_STAT ? AW'(OFS_SECURE) :
						{addr_q[AW-1:12], OFS_PROT};
				end
			end
			OP_NVLB_READ, OP_VLB_READ: begin
				step_wr = 1'b0;
				step_addr = addr_q;
			end
			OP_PWD_UNLOCK: begin
				nsteps = 4'd7;
				step_data = step_q == 4'd0 ? CD_WBUF : step_q == 4'd1 ? 8'(PWD_WORDS - 1) :
					step_q == 4'd6 ? CD_CONFIRM : pwd_q[8*(step_q-4'd2) +: 8];
				if (step_q >= 4'd2 && step_q <= 4'd5)
					step_addr = AW'(step_q - 4'd2);
			end
			OP_WBUF_HDR: begin
				nsteps = in_bypass_q ? 4'd2 : 4'd4;
				{step_wr, step_addr, step_data} = cyc_of(in_bypass_q ? step_q + 4'd2 : step_q,
					CD_WBUF);
				if (step_q >= nsteps - 4'd2) begin
					step_addr = addr_q;
					step_data = step_q == nsteps - 4'd1 ? data_q : CD_WBUF;
				end
			end
			OP_WBUF_LOAD: begin
				step_addr = addr_q;
			end
			OP_WBUF_CONFIRM: begin
				step_addr = addr_q;
				step_data = CD_CONFIRM;
			end
			default: begin
				step_wr = 1'b0;
			end
		endcase
	end

	assign cyc.req = st_q == ST_ISSUE;
	assign cyc.wr = step_wr;
	assign cyc.addr = step_addr;
	assign cyc.wdata = step_data;

	// sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			op_q <= OP_READ;
			step_q <= 4'd0;
			rdat_q <= 8'h00;
		end else begin
			unique case (st_q)
				ST_IDLE: if (go && legal) begin
					op_q <= go_op;
					step_q <= 4'd0;
					st_q <= ST_ISSUE;
				end
				ST_ISSUE: st_q <= ST_WAIT;
				ST_WAIT: if (cyc.ack) begin
					if (!step_wr)
						rdat_q <= cyc.rdata;
					if (step_q + 4'd1 >= nsteps) begin
						st_q <= ST_IDLE;
					end else begin
						step_q <= step_q + 4'd1;
						st_q <= ST_ISSUE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// mode tracking and buffered-write cycle count
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_bypass_q <= 1'b0;
			in_wbuf_q <= 1'b0;
			buf_cyc_q <= '0;
		end else if (st_q == ST_IDLE && go && legal) begin
			unique case (go_op)
				OP_BYP_ENTER: in_bypass_q <= 1'b1;
				OP_EXIT, OP_RESET: in_bypass_q <= 1'b0;
				default: in_bypass_q <= in_bypass_q;
			endcase
			if (go_op == OP_WBUF_HDR) begin
				in_wbuf_q <= 1'b1;
				buf_cyc_q <= in_bypass_q ? 10'd2 : 10'd4;
			end else if (go_op == OP_WBUF_LOAD) begin
				buf_cyc_q <= buf_cyc_q + 10'd1;
			end else begin
				in_wbuf_q <= 1'b0;
			end
		end
	end

	// acceleration input high during lock-bit set and volatile lock-bit clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			acceleration_input_q <= 1'b0;
		else
			acceleration_input_q <= st_q != ST_IDLE && (op_q == OP_NVLB_SET ||
				op_q == OP_VLB_SET || op_q == OP_VLB_CLR);
	end

	// apb slave: one wait state, reads and writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			addr_q <= '0;
			data_q <= 8'h00;
			pwd_q <= 32'h0000_0000;
			done_q <= 1'b0;
			refuse_q <= 1'b0;
		end else begin
			pready_q <= apb_wr || apb_rd;
			pslverr_q <= 1'b0;
			if (st_q == ST_WAIT && cyc.ack && step_q + 4'd1 >= nsteps)
				done_q <= 1'b1;
			else if (go && legal)
				done_q <= 1'b0;
			if (go)
				refuse_q <= !legal;
			if (apb_wr) begin
				unique case (paddr)
					REG_CTRL: ;
					REG_ADDR: if (st_q == ST_IDLE) addr_q <= pwdata[AW-1:0];
					REG_DATA: if (st_q == ST_IDLE) data_q <= pwdata[7:0];
					REG_PWD: if (st_q == ST_IDLE) pwd_q <= pwdata;
					default: pslverr_q <= 1'b1;
				endcase
			end
			if (apb_rd) begin
				unique case (paddr)
					REG_CTRL: prdata_q <= 32'({op_q});
					REG_ADDR: prdata_q <= 32'(addr_q);
					REG_DATA: prdata_q <= 32'(data_q);
					REG_STAT: prdata_q <= 32'({refuse_q, in_bypass_q, done_q, st_q != ST_IDLE});
					REG_RDAT: prdata_q <= 32'(rdat_q);
					REG_PWD: prdata_q <= pwd_q;
					default: begin
						prdata_q <= 32'h0000_0000;
						pslverr_q <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/fbc_pin_engine.sv]
/*
 pin engine: runs one asynchronous write or read cycle on the flash pins.
 assumes the flash meets the strobe widths given in the package.
*/
`timescale 1ns/1ns
`default_nettype none
module fbc_pin_engine
	import fbc_pkg::*;
#(
	parameter int AW = 23
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// request side
	fbc_cyc_if.eng cyc,
	// flash pins
	output logic [AW-1:0] fl_addr_q,
	output logic fl_ce_n_q,
	output logic fl_we_n_q,
	output logic fl_oe_n_q,
	output logic [7:0] fl_dq_out_q,
	output logic fl_dq_oe_q,
	input wire logic [7:0] fl_dq_in
);
	localparam int CW = 4;
	initial begin
		if (WE_CYC >= 2 ** CW || RD_CYC >= 2 ** CW || WE_CYC < 1)
			$error("strobe counts do not fit");
	end
	logic [CW-1:0] cnt_q;
	logic act_q;
	logic ack_q;
	logic [7:0] rdata_q;
	assign cyc.ack = ack_q;
	assign cyc.rdata = rdata_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_q <= 1'b0;
			cnt_q <= '0;
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
			fl_addr_q <= '0;
			fl_ce_n_q <= 1'b1;
			fl_we_n_q <= 1'b1;
			fl_oe_n_q <= 1'b1;
			fl_dq_out_q <= 8'h00;
			fl_dq_oe_q <= 1'b0;
		end else begin
			ack_q <= 1'b0;
			if (!act_q && cyc.req && !ack_q) begin
				act_q <= 1'b1;
				fl_addr_q <= cyc.addr;
				fl_ce_n_q <= 1'b0;
				fl_we_n_q <= !cyc.wr;
				fl_oe_n_q <= cyc.wr;
				fl_dq_out_q <= cyc.wdata;
				fl_dq_oe_q <= cyc.wr;
				cnt_q <= cyc.wr ? CW'(WE_CYC) : CW'(RD_CYC);
			end else if (act_q) begin
				if (cnt_q > 1) begin
					cnt_q <= cnt_q - 1'b1;
				end else begin
					act_q <= 1'b0;
					ack_q <= 1'b1;
					rdata_q <= fl_dq_in;
					fl_ce_n_q <= 1'b1;
					fl_we_n_q <= 1'b1;
					fl_oe_n_q <= 1'b1;
					fl_dq_oe_q <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/fbc_pkg.sv]
/*
 package for the flash command sequencer: register map of the controller's own
 apb registers, command codes for the x8 byte-mode flash, op encodings, timing.
 assumes nothing of its surroundings.
*/
package fbc_pkg;
	// apb register byte offsets (own map)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam logic [7:0] REG_RDAT = 8'h10;
	localparam logic [7:0] REG_PWD = 8'h14;
	// ctrl fields
	localparam int CTRL_GO_BIT = 31;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W = 5;
	// status fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_LOCK_BIT = 2;
	localparam int STAT_REFUSE_BIT = 3;
	// flash unlock addresses and codes (byte mode)
	localparam logic [11:0] ADR_AAA = 12'haaa;
	localparam logic [11:0] ADR_555 = 12'h555;
	localparam logic [7:0] CD_AA = 8'haa;
	localparam logic [7:0] CD_55 = 8'h55;
	localparam logic [7:0] CD_RESET = 8'hf0;
	localparam logic [7:0] CD_PROG = 8'ha0;
	localparam logic [7:0] CD_ERASE = 8'h80;
	localparam logic [7:0] CD_CHIP = 8'h10;
	localparam logic [7:0] CD_SECT = 8'h30;
	localparam logic [7:0] CD_BYPASS = 8'h20;
	localparam logic [7:0] CD_AUTOSEL = 8'h90;
	localparam logic [7:0] CD_ZERO = 8'h00;
	localparam logic [7:0] CD_ONE = 8'h01;
	localparam logic [7:0] CD_WBUF = 8'h25;
	localparam logic [7:0] CD_CONFIRM = 8'h29;
	localparam logic [7:0] CD_SRRD = 8'h70;
	localparam logic [7:0] CD_SRCLR = 8'h71;
	localparam logic [7:0] CD_SUSP_LEG = 8'hb0;
	localparam logic [7:0] CD_RES_LEG = 8'h30;
	localparam logic [7:0] CD_SUSP_ENH = 8'h51;
	localparam logic [7:0] CD_RES_ENH = 8'h50;
	localparam logic [7:0] CD_ENT_NVLB = 8'hc0;
	localparam logic [7:0] CD_ENT_VLB = 8'he0;
	localparam logic [7:0] CD_ENT_PWD = 8'h60;
	localparam logic [11:0] OFS_PROT = 12'h004;
	localparam logic [11:0] OFS_SECURE = 12'h006;
	localparam int PWD_WORDS = 4;
	localparam int MAX_STEPS = 12;
	// controller operations
	typedef enum logic [4:0] {
		OP_READ = 5'h00, OP_RESET = 5'h01, OP_PROG = 5'h02, OP_CHIP_ERASE = 5'h03,
		OP_SECT_ERASE = 5'h04, OP_BYP_ENTER = 5'h05, OP_BYP_PROG = 5'h06,
		OP_BYP_SECT = 5'h07, OP_BYP_CHIP = 5'h08, OP_EXIT = 5'h09, OP_SR_READ = 5'h0a,
		OP_SR_CLEAR = 5'h0b, OP_PROT_VERIFY = 5'h0c, OP_SECURE_STAT = 5'h0d,
		OP_SUSP_ENH = 5'h0e, OP_RES_ENH = 5'h0f, OP_SUSP_LEG = 5'h10,
		OP_RES_LEG = 5'h11, OP_ABORT_RST = 5'h12, OP_NVLB_SET = 5'h13,
		OP_NVLB_ERASE = 5'h14, OP_NVLB_READ = 5'h15, OP_VLB_SET = 5'h16,
		OP_VLB_CLR = 5'h17, OP_VLB_READ = 5'h18, OP_PWD_UNLOCK = 5'h19,
		OP_PWD_PROG = 5'h1a, OP_WBUF_HDR = 5'h1b, OP_WBUF_LOAD = 5'h1c,
		OP_WBUF_CONFIRM = 5'h1d
	} fbc_op_type;
	// bus cycle timing on the flash pins, 50 MHz clock
	localparam int CLK_NS = 20;
	localparam int T_WE_NS = 50;
	localparam int T_RD_NS = 80;
	localparam int WE_CYC = (T_WE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [testbench/fbc_flash_model.sv]
/*
 byte-mode flash partner: logs up to 64 write cycles as {acceleration level, address, data}
 and answers read cycles.
 assumes the host drives the strobes and that only one write is in flight.
*/
`timescale 1ns/1ns
`default_nettype none
module fbc_flash_model
	import fbc_pkg::*;
#(
	parameter int AW = 23,
	parameter logic [7:0] SEC_STAT = 8'h80
) (
	// flash pins
	input wire logic [AW-1:0] fl_addr,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic [7:0] fl_dq,
	input wire logic acceleration_input,
	output logic [7:0] fl_dq_in
);
	logic [31:0] log_q [64];
	int n = 0;
	logic asel_q = 1'b0;
	logic wr_active;
	// ce and we rise together, so latch when the first of the two strobes rises
	assign wr_active = !fl_we_n && !fl_ce_n;
	always @(negedge wr_active) begin
		if (n < 64) begin
			log_q[n] = {acceleration_input, 23'(fl_addr), fl_dq};
			n++;
			if (fl_dq == CD_AUTOSEL && fl_addr[11:0] == ADR_AAA) asel_q = 1'b1;
			if (fl_dq == CD_RESET) asel_q = 1'b0;
		end
	end
	// idle bus shows the inverse of what a read would return, except autoselect reads at OFS_PROT and OFS_SECURE
	always @* begin
		if (!fl_ce_n && !fl_oe_n && asel_q && fl_addr[11:0] == OFS_PROT) fl_dq_in = CD_ONE;
		else if (!fl_ce_n && !fl_oe_n && asel_q && fl_addr[11:0] == OFS_SECURE) fl_dq_in = SEC_STAT;
		else if (!fl_ce_n && !fl_oe_n) fl_dq_in = fl_addr[7:0] ^ 8'h3c;
		else fl_dq_in = ~(fl_addr[7:0] ^ 8'h3c);
	end
endmodule
`default_nettype wire

// [testbench/fbc_host_asserts.sv]
/*
 checker for the flash command sequencer, watching its top-level ports.
 assumes one clock domain and the package timing of the pin engine.
*/
`timescale 1ns/1ns
`default_nettype none
module fbc_host_asserts
	import fbc_pkg::*;
#(
	parameter int AW = 23,
	parameter int BUF_MAX_CYC = 261
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata_q,
	input wire logic pready_q,
	input wire logic pslverr_q,
	// flash pins
	input wire logic [AW-1:0] fl_addr_q,
	input wire logic fl_ce_n_q,
	input wire logic fl_we_n_q,
	input wire logic fl_oe_n_q,
	input wire logic [7:0] fl_dq_out_q,
	input wire logic fl_dq_oe_q,
	input wire logic [7:0] fl_dq_in,
	input wire logic acceleration_input_q
);
	logic we_q;
	logic wr_start;
	logic [7:0] pwd_q;
	logic [AW-1:0] pwa_q;
	assign wr_start = we_q && !fl_we_n_q;
	// remembers the previous write cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			we_q <= 1'b1;
			pwd_q <= 8'h00;
			pwa_q <= '0;
		end else begin
			we_q <= fl_we_n_q;
			if (wr_start) pwd_q <= fl_dq_out_q;
			if (wr_start) pwa_q <= fl_addr_q;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_we_pulse;
		!fl_we_n_q [*3] ##1 fl_we_n_q;
	endsequence
	sequence s_oe_pulse;
		!fl_oe_n_q [*4] ##1 fl_oe_n_q;
	endsequence
	property p_wr_shape;
		wr_start |-> s_we_pulse;
	endproperty
	property p_wr_hold;
		!fl_we_n_q && !we_q |-> $stable(fl_addr_q) && $stable(fl_dq_out_q) && !fl_ce_n_q && fl_dq_oe_q;
	endproperty
	property p_rd_shape;
		$fell(fl_oe_n_q) |-> (fl_we_n_q && !fl_dq_oe_q && !fl_ce_n_q) ##0 s_oe_pulse;
	endproperty
	property p_no_clash;
		!(!fl_we_n_q && !fl_oe_n_q);
	endproperty
	property p_unlock;
		wr_start && pwd_q == CD_AA && pwa_q == AW'(ADR_AAA) |-> fl_dq_out_q == CD_55 && fl_addr_q == AW'(ADR_555);
	endproperty
	property p_exit;
		wr_start && pwd_q == CD_AUTOSEL && pwa_q == '0 |-> fl_dq_out_q == CD_ZERO;
	endproperty
	property p_sr;
		wr_start && fl_dq_out_q == CD_SRRD && fl_addr_q == AW'(ADR_AAA) |-> ##[1:12] $fell(fl_oe_n_q);
	endproperty
	property p_apb_err;
		psel && penable && !pready_q && paddr > REG_PWD |=> pready_q && pslverr_q;
	endproperty
	a_wr_shape: assert property (p_wr_shape) else $error("write strobe width wrong");
	a_wr_hold: assert property (p_wr_hold) else $error("write cycle not held");
	a_rd_shape: assert property (p_rd_shape) else $error("read strobe wrong");
	a_no_clash: assert property (p_no_clash) else $error("write and read strobes together");
	a_unlock: assert property (p_unlock) else $error("second unlock cycle wrong");
	a_exit: assert property (p_exit) else $error("exit pair broken");
	a_sr: assert property (p_sr) else $error("status read not followed by read");
	a_apb_err: assert property (p_apb_err) else $error("unmapped access not refused");
endmodule
bind fbc_host fbc_host_asserts #(.AW(AW), .BUF_MAX_CYC(BUF_MAX_CYC)) i_fbc_host_asserts (
	.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
	.pslverr_q(pslverr_q), .fl_addr_q(fl_addr_q), .fl_ce_n_q(fl_ce_n_q), .fl_we_n_q(fl_we_n_q),
	.fl_oe_n_q(fl_oe_n_q), .fl_dq_out_q(fl_dq_out_q), .fl_dq_oe_q(fl_dq_oe_q),
	.fl_dq_in(fl_dq_in), .acceleration_input_q(acceleration_input_q));
`default_nettype wire

// [testbench/tb.sv]
/*
 self-checking bench for the flash command sequencer over apb.
 assumes the flash partner model logs write cycles as {acceleration level, address, data}.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
	import fbc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready_q, pslverr_q, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata_q, rd;
	logic [22:0] fl_addr_q;
	logic fl_ce_n_q, fl_we_n_q, fl_oe_n_q, fl_dq_oe_q, acceleration_input_q;
	logic [7:0] fl_dq_out_q, fl_dq_in;
	int error_cnt = 0, comparisons = 0;
	always #10 sys_clk = ~sys_clk;
	fbc_host i_fbc_host (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
		.pready_q(pready_q), .pslverr_q(pslverr_q), .fl_addr_q(fl_addr_q),
		.fl_ce_n_q(fl_ce_n_q), .fl_we_n_q(fl_we_n_q), .fl_oe_n_q(fl_oe_n_q),
		.fl_dq_out_q(fl_dq_out_q), .fl_dq_oe_q(fl_dq_oe_q), .fl_dq_in(fl_dq_in),
		.acceleration_input_q(acceleration_input_q));
	fbc_flash_model i_fbc_flash_model (.fl_addr(fl_addr_q), .fl_ce_n(fl_ce_n_q),
		.fl_we_n(fl_we_n_q), .fl_oe_n(fl_oe_n_q), .fl_dq(fl_dq_out_q),
		.acceleration_input(acceleration_input_q), .fl_dq_in(fl_dq_in));
	task automatic print_verdict();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready_q !== 1'b1 && k < 50);
		rd = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) error_cnt++;
		if (k >= 50) print_verdict();
		@(posedge sys_clk);
	endtask
	// posts one operation and polls status until it is no longer busy
	task automatic run_op(input fbc_op_type op, input logic [31:0] a, input logic [31:0] d);
		int k;
		apb(1'b1, REG_ADDR, a);
		apb(1'b1, REG_DATA, d);
		i_fbc_flash_model.n = 0;
		apb(1'b1, REG_CTRL, {1'b1, 26'h0, op});
		k = 0;
		do begin
			apb(1'b0, REG_STAT, 32'h0);
			k++;
		end while ((rd[STAT_BUSY_BIT] !== 1'b0 || rd[STAT_DONE_BIT] !== 1'b1) && k < 200);
		if (k >= 200) error_cnt++;
		if (k >= 200) print_verdict();
	endtask
	task automatic seq(input int at, input logic [31:0] e [$]);
		check(32'(i_fbc_flash_model.n), 32'(at + e.size()));
		foreach (e[i]) check(i_fbc_flash_model.log_q[at + i], e[i]);
	endtask
	task automatic sc_read();
		run_op(OP_READ, 32'h123, 32'h0);
		check(32'(i_fbc_flash_model.n), 32'h0);
		apb(1'b0, REG_RDAT, 32'h0);
		check(rd, 32'h1f);
		apb(1'b0, 8'h20, 32'h0);
		check({31'h0, err}, 32'h1);
	endtask
	task automatic sc_prog_erase();
		run_op(OP_PROG, 32'h1234, 32'h5a);
		seq(0, {32'haaaaa, 32'h55555, 32'haaaa0, 32'h12345a});
		run_op(OP_CHIP_ERASE, 32'h0, 32'h0);
		seq(0, {32'haaaaa, 32'h55555, 32'haaa80, 32'haaaaa, 32'h55555, 32'haaa10});
		run_op(OP_SECT_ERASE, 32'h48abc, 32'h0);
		check({24'h0, i_fbc_flash_model.log_q[5][30:23]}, 32'h9);
		check(i_fbc_flash_model.log_q[5][7:0], 32'h30);
	endtask
	task automatic sc_bypass();
		run_op(OP_BYP_PROG, 32'h40, 32'h66);
		check({31'h0, rd[STAT_REFUSE_BIT]}, 32'h1);
		check(32'(i_fbc_flash_model.n), 32'h0);
		run_op(OP_BYP_ENTER, 32'h0, 32'h0);
		seq(0, {32'haaaaa, 32'h55555, 32'haaa20});
		check({31'h0, rd[STAT_LOCK_BIT]}, 32'h1);
		run_op(OP_BYP_PROG, 32'h40, 32'h66);
		seq(0, {32'ha0, 32'h4066});
		run_op(OP_EXIT, 32'h0, 32'h0);
		seq(0, {32'h90, 32'h00});
		check({31'h0, rd[STAT_LOCK_BIT]}, 32'h0);
	endtask
	task automatic sc_suspend();
		fbc_op_type ops [4] = '{OP_SUSP_ENH, OP_RES_ENH, OP_SUSP_LEG, OP_RES_LEG};
		logic [7:0] cd [4] = '{8'h51, 8'h50, 8'hb0, 8'h30};
		foreach (ops[i]) begin
			run_op(ops[i], 32'h0, 32'h0);
			check({i_fbc_flash_model.n[23:0], i_fbc_flash_model.log_q[0][7:0]}, {24'h1, cd[i]});
		end
	endtask
	task automatic sc_status();
		run_op(OP_SR_READ, 32'h0, 32'h0);
		seq(0, {32'haaa70});
		apb(1'b0, REG_RDAT, 32'h0);
		check(rd, 32'h3c);
		run_op(OP_SR_CLEAR, 32'h0, 32'h0);
		seq(0, {32'haaa71});
		run_op(OP_ABORT_RST, 32'h0, 32'h0);
		seq(0, {32'haaaaa, 32'h55555, 32'haaaf0});
	endtask
	task automatic sc_autosel();
		run_op(OP_PROT_VERIFY, 32'h18000, 32'h0);
		check(i_fbc_flash_model.log_q[2], 32'haaa90);
		apb(1'b0, REG_RDAT, 32'h0);
		check(rd, 32'h01);
		run_op(OP_SECURE_STAT, 32'h0, 32'h0);
		apb(1'b0, REG_RDAT, 32'h0);
		check(rd, 32'h80);
		run_op(OP_RESET, 32'h0, 32'h0);
		seq(0, {32'hf0});
	endtask
	task automatic sc_password();
		apb(1'b1, REG_PWD, 32'h44332211);
		run_op(OP_PWD_UNLOCK, 32'h0, 32'h0);
		seq(0, {32'h25, 32'h03, 32'h11, 32'h122, 32'h233, 32'h344, 32'h29});
	endtask
	// lock-bit ops with the acceleration level in log bit 31, then a full write buffer
	task automatic sc_lock_wbuf();
		int k;
		run_op(OP_VLB_SET, 32'h28000, 32'h0);
		seq(0, {32'h800000a0, 32'h82800000});
		run_op(OP_VLB_CLR, 32'h28000, 32'h0);
		seq(0, {32'h800000a0, 32'h82800001});
		run_op(OP_NVLB_ERASE, 32'h0, 32'h0);
		seq(0, {32'h80, 32'h30});
		run_op(OP_VLB_READ, 32'h28000, 32'h0);
		check(32'(i_fbc_flash_model.n), 32'h0);
		apb(1'b0, REG_RDAT, 32'h0);
		check(rd, 32'h3c);
		run_op(OP_PWD_PROG, 32'h102, 32'h77);
		seq(0, {32'ha0, 32'h277});
		run_op(OP_WBUF_LOAD, 32'h30000, 32'h12);
		check({31'h0, rd[STAT_REFUSE_BIT]}, 32'h1);
		run_op(OP_WBUF_HDR, 32'h30000, 32'hff);
		seq(0, {32'haaaaa, 32'h55555, 32'h3000025, 32'h30000ff});
		// 261 cycles less four header cycles and the confirm leave 256 loads
		k = 0;
		for (int i = 0; i < 256; i++) begin
			run_op(OP_WBUF_LOAD, 32'h30000 + 32'(i), 32'(i));
			k += i_fbc_flash_model.n;
		end
		check(32'(k), 32'd256);
		check(i_fbc_flash_model.log_q[0], 32'h300ffff);
		run_op(OP_WBUF_LOAD, 32'h30000, 32'h12);
		check({31'h0, rd[STAT_REFUSE_BIT]}, 32'h1);
		run_op(OP_WBUF_CONFIRM, 32'h30000, 32'h0);
		seq(0, {32'h3000029});
		check({31'h0, rd[STAT_REFUSE_BIT]}, 32'h0);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		sc_read();
		sc_prog_erase();
		sc_bypass();
		sc_suspend();
		sc_status();
		sc_autosel();
		sc_password();
		sc_lock_wbuf();
		print_verdict();
	end
endmodule
`default_nettype wire
